// ### rtl/itc_defs.svh
// Register addresses, field positions and reset values of the interval timer.
`ifndef ITC_DEFS_SVH
`define ITC_DEFS_SVH

`define ITC_ADDR_SUPPLY    20'hf00f3
`define ITC_ADDR_LOW       20'hfff90
`define ITC_ADDR_HIGH      20'hfff91

`define ITC_SUPPLY_BIT     4
`define ITC_RUN_BIT        7
`define ITC_CMPH_MSB       3

`define ITC_SUPPLY_RST     8'h00
`define ITC_LOW_RST        8'hff
`define ITC_HIGH_RST       8'h0f

`endif

// ### rtl/itc_pkg.sv
// Types shared by the interval timer modules.
package itc_pkg;

   typedef enum logic [1:0] {
      ITC_SEL_NONE   = 2'b00,
      ITC_SEL_SUPPLY = 2'b01,
      ITC_SEL_LOW    = 2'b10,
      ITC_SEL_HIGH   = 2'b11
   } itc_sel_t;

   typedef logic [11:0] itc_cnt_t;

endpackage : itc_pkg

// ### rtl/itc_tick.sv
// Count clock edge detector that turns the slow oscillator into one-cycle ticks.
`timescale 1ns/1ns
module itc_tick (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic osc_clk,
   input  wire logic supply_en,
   output logic      tick_r
);

   logic osc_prev_r;

   always_ff @(posedge mclk) begin
      if (reset) begin
         osc_prev_r <= 1'b0;
      end else begin
         osc_prev_r <= osc_clk;
      end
   end

   // The previous level keeps following the pin while gated, so re-enabling makes no false edge.
   always_ff @(posedge mclk) begin
      if (reset) begin
         tick_r <= 1'b0;
      end else begin
         tick_r <= supply_en & osc_clk & ~osc_prev_r;
      end
   end

endmodule : itc_tick

// ### rtl/itc_timer.sv
// Twelve-bit interval timer with its count clock supply and control registers.
// How it works
// - Count clock ticks only while the supply select bit is one.
// - Supply select sits at bit four; other bits read zero; resets to zero.
// - Reset loads high register with 0f and low register with ff.
// - Run enable at bit seven; zero stops and clears the counter.
// - Interrupt every compare plus one count clocks; compare zero is forbidden.
// - Run enable reads back as one only after one count clock.
// - One high register write updates compare high bits and run enable together.
// - Registers are written as whole bytes only.
// - On match the counter clears, keeps counting and pulses the interrupt.
// - With the clock gate low the low and high registers reset and ignore writes.
`timescale 1ns/1ns
`include "itc_defs.svh"
module itc_timer #(
   parameter int ADDR_W = 20
) (
   input  wire logic              mclk,
   input  wire logic              reset,
   input  wire logic [ADDR_W-1:0] cpu_addr,
   input  wire logic [7:0]        cpu_wdata,
   input  wire logic              cpu_we,
   input  wire logic              cpu_re,
   output logic      [7:0]        cpu_rdata_r,
   input  wire logic              timer_clock_gate,
   input  wire logic              low_speed_osc_clock,
   output logic                   interval_irq_r
);

   localparam logic [7:0] SUPPLY_RST = `ITC_SUPPLY_RST;
   localparam logic [7:0] LOW_RST    = `ITC_LOW_RST;
   localparam logic [7:0] HIGH_RST   = `ITC_HIGH_RST;

   function automatic itc_pkg::itc_sel_t itc_decode(input logic [ADDR_W-1:0] addr);
      itc_pkg::itc_sel_t sel;
      sel = itc_pkg::ITC_SEL_NONE;
      if (addr == ADDR_W'(`ITC_ADDR_SUPPLY)) begin
         sel = itc_pkg::ITC_SEL_SUPPLY;
      end else if (addr == ADDR_W'(`ITC_ADDR_LOW)) begin
         sel = itc_pkg::ITC_SEL_LOW;
      end else if (addr == ADDR_W'(`ITC_ADDR_HIGH)) begin
         sel = itc_pkg::ITC_SEL_HIGH;
      end
      return sel;
   endfunction : itc_decode

   itc_pkg::itc_sel_t sel;
   logic              count_clock_supply_sel_r;
   itc_pkg::itc_cnt_t compare_value_r;
   logic              run_enable_wr_r;
   logic              run_enable_r;
   itc_pkg::itc_cnt_t count_r;
   logic              tick;
   logic              match;
   logic              wr_supply;
   logic              wr_low;
   logic              wr_high;
   logic              timer_hold;
   logic [7:0]        rd_supply;
   logic [7:0]        rd_high;

   assign sel        = itc_decode(cpu_addr);
   assign timer_hold = reset | ~timer_clock_gate;
   // Every write carries a full byte; there is no bit-level write path.
   assign wr_supply  = cpu_we & (sel == itc_pkg::ITC_SEL_SUPPLY);
   assign wr_low     = cpu_we & (sel == itc_pkg::ITC_SEL_LOW) & timer_clock_gate;
   assign wr_high    = cpu_we & (sel == itc_pkg::ITC_SEL_HIGH) & timer_clock_gate;
   assign match      = (count_r == compare_value_r);

   itc_tick u_tick (
      .mclk      (mclk),
      .reset     (reset),
      .osc_clk   (low_speed_osc_clock),
      .supply_en (count_clock_supply_sel_r),
      .tick_r    (tick)
   );

   // The supply register survives the clock gate so the count source can be chosen first.
   always_ff @(posedge mclk) begin
      if (reset) begin
         count_clock_supply_sel_r <= SUPPLY_RST[`ITC_SUPPLY_BIT];
      end else if (wr_supply) begin
         count_clock_supply_sel_r <= cpu_wdata[`ITC_SUPPLY_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (timer_hold) begin
         compare_value_r <= {HIGH_RST[`ITC_CMPH_MSB:0], LOW_RST};
      end else begin
         if (wr_low) begin
            compare_value_r[7:0] <= cpu_wdata;
         end
         if (wr_high) begin
            compare_value_r[11:8] <= cpu_wdata[`ITC_CMPH_MSB:0];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (timer_hold) begin
         run_enable_wr_r <= HIGH_RST[`ITC_RUN_BIT];
      end else if (wr_high) begin
         run_enable_wr_r <= cpu_wdata[`ITC_RUN_BIT];
      end
   end

   // Starting waits for a count clock edge; stopping acts on the next mclk edge, so a tick in that cycle still counts.
   always_ff @(posedge mclk) begin
      if (timer_hold) begin
         run_enable_r <= 1'b0;
      end else if (!run_enable_wr_r) begin
         run_enable_r <= 1'b0;
      end else if (tick) begin
         run_enable_r <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (timer_hold || !run_enable_r) begin
         count_r <= '0;
      end else if (tick) begin
         if (match) begin
            count_r <= '0;
         end else begin
            count_r <= count_r + 12'h001;
         end
      end
   end

   // A compare value of zero would fire on every tick; software must not program it.
   always_ff @(posedge mclk) begin
      if (timer_hold) begin
         interval_irq_r <= 1'b0;
      end else begin
         interval_irq_r <= run_enable_r & tick & match;
      end
   end

   always_comb begin
      rd_supply = 8'h00;
      rd_supply[`ITC_SUPPLY_BIT] = count_clock_supply_sel_r;
      rd_high = 8'h00;
      rd_high[`ITC_RUN_BIT] = run_enable_r;
      rd_high[`ITC_CMPH_MSB:0] = compare_value_r[11:8];
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         cpu_rdata_r <= 8'h00;
      end else if (cpu_re) begin
         case (sel)
            itc_pkg::ITC_SEL_SUPPLY: begin
               cpu_rdata_r <= rd_supply;
            end
            itc_pkg::ITC_SEL_LOW: begin
               cpu_rdata_r <= timer_clock_gate ? compare_value_r[7:0] : LOW_RST;
            end
            itc_pkg::ITC_SEL_HIGH: begin
               cpu_rdata_r <= timer_clock_gate ? rd_high : HIGH_RST;
            end
            default: begin
               cpu_rdata_r <= 8'h00;
            end
         endcase
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   a_tick_gated: assert property (!count_clock_supply_sel_r |=> !tick)
      else $error("Count clock ticked with supply stopped.");

   a_supply_fields: assert property (cpu_re && sel == itc_pkg::ITC_SEL_SUPPLY |=>
      (cpu_rdata_r & 8'hef) == 8'h00)
      else $error("Supply register fixed bits not zero.");

   a_high_fields: assert property (cpu_re && sel == itc_pkg::ITC_SEL_HIGH |=>
      (cpu_rdata_r & 8'h70) == 8'h00)
      else $error("High register fixed bits not zero.");

   a_reset_values: assert property ($past(reset) |->
      compare_value_r == 12'hfff && !run_enable_wr_r && !count_clock_supply_sel_r)
      else $error("Wrong values after reset.");

   // A restart write may follow at once, so only the next cycle is sure to show the stop.
   a_stop_clears: assert property (!run_enable_wr_r |=> !run_enable_r ##1 count_r == 12'h000)
      else $error("Counter not cleared after stop.");

   a_irq_on_match: assert property (interval_irq_r |->
      $past(tick) && $past(match) && $past(run_enable_r))
      else $error("Interrupt without a compare match.");

   a_match_fires: assert property (run_enable_r && tick && match && timer_clock_gate |=>
      interval_irq_r && count_r == 12'h000)
      else $error("Match did not clear counter and pulse interrupt.");

   a_run_sync: assert property ($rose(run_enable_r) |-> $past(tick) && $past(run_enable_wr_r))
      else $error("Run enable read back before a count clock.");

   a_high_write: assert property (wr_high |=>
      run_enable_wr_r == $past(cpu_wdata[7]) && compare_value_r[11:8] == $past(cpu_wdata[3:0]))
      else $error("High register write not taken whole.");

   a_gate_hold: assert property (!timer_clock_gate |=>
      compare_value_r == 12'hfff && !run_enable_r && count_r == 12'h000)
      else $error("Timer not held while clock gate low.");

   a_count_step: assert property (run_enable_r && tick && !match && timer_clock_gate && run_enable_wr_r |=>
      count_r == $past(count_r) + 12'h001)
      else $error("Counter did not step by one.");

endmodule : itc_timer

// ### dv/tb_top.sv
// Self-checking bench for the interval timer.
`timescale 1ns/1ns
`include "itc_defs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_top;
   logic        mclk;
   logic        reset;
   logic [19:0] cpu_addr;
   logic [7:0]  cpu_wdata;
   logic        cpu_we;
   logic        cpu_re;
   logic [7:0]  cpu_rdata_r;
   logic        timer_clock_gate;
   logic [2:0]  osc_cnt;
   logic        interval_irq_r;
   int          num_errors;
   int          check_count;
   int          cycles;

   itc_timer itc_timer_i (
      .mclk                (mclk),
      .reset               (reset),
      .cpu_addr            (cpu_addr),
      .cpu_wdata           (cpu_wdata),
      .cpu_we              (cpu_we),
      .cpu_re              (cpu_re),
      .cpu_rdata_r         (cpu_rdata_r),
      .timer_clock_gate    (timer_clock_gate),
      .low_speed_osc_clock (osc_cnt[2]),
      .interval_irq_r      (interval_irq_r)
   );

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // The slow oscillator runs at one eighth of mclk so that long periods stay affordable.
   always @(posedge mclk) begin
      osc_cnt <= osc_cnt + 3'h1;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   task automatic wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1 cpu_addr = a;
      cpu_wdata = d;
      cpu_we = 1'b1;
      @(posedge mclk);
      #1 cpu_we = 1'b0;
   endtask : wr

   task automatic rdc(input logic [19:0] a, input logic [7:0] e);
      @(posedge mclk);
      #1 cpu_addr = a;
      cpu_re = 1'b1;
      @(posedge mclk);
      #1 cpu_re = 1'b0;
      `CHK(cpu_rdata_r, e)
   endtask : rdc

   // Measures mclk cycles between two interrupt pulses and checks the pulse is one cycle wide.
   task automatic period(input int exp);
      int n;
      n = 0;
      while (interval_irq_r !== 1'b1 && n < 9000) begin
         @(posedge mclk);
         #1 n++;
      end
      @(posedge mclk);
      #1 `CHK(interval_irq_r, 1'b0)
      n = 1;
      do begin
         @(posedge mclk);
         #1 n++;
      end while (interval_irq_r !== 1'b1 && n < 9000);
      `CHK(n, exp)
   endtask : period

   task automatic t_reset_gate;
      rdc(`ITC_ADDR_SUPPLY, `ITC_SUPPLY_RST);
      rdc(`ITC_ADDR_LOW, `ITC_LOW_RST);
      rdc(`ITC_ADDR_HIGH, `ITC_HIGH_RST);
      rdc(20'h00000, 8'h00);
      wr(`ITC_ADDR_LOW, 8'h12);
      rdc(`ITC_ADDR_LOW, 8'hff);
      wr(`ITC_ADDR_SUPPLY, 8'hff);
      rdc(`ITC_ADDR_SUPPLY, 8'h10);
      timer_clock_gate = 1'b1;
      rdc(`ITC_ADDR_LOW, 8'hff);
   endtask : t_reset_gate

   task automatic t_run_short;
      wr(`ITC_ADDR_LOW, 8'h01);
      // Start just after the oscillator falls, so no count edge can land before the read.
      while (osc_cnt !== 3'h0) @(posedge mclk);
      #1 wr(`ITC_ADDR_HIGH, 8'h80);
      rdc(`ITC_ADDR_HIGH, 8'h00);
      repeat (16) @(posedge mclk);
      rdc(`ITC_ADDR_HIGH, 8'h80);
      period(16);
   endtask : t_run_short

   task automatic t_run_wide;
      // The interrupt mask lives outside the block, so a pulse during the stop is simply not measured.
      wr(`ITC_ADDR_HIGH, 8'h01);
      repeat (2) @(posedge mclk);
      rdc(`ITC_ADDR_HIGH, 8'h01);
      // The period task waits for a fresh pulse, as a cleared request flag would.
      wr(`ITC_ADDR_HIGH, 8'h81);
      period(2064);
   endtask : t_run_wide

   task automatic t_supply_off;
      wr(`ITC_ADDR_HIGH, 8'h00);
      wr(`ITC_ADDR_SUPPLY, 8'h00);
      wr(`ITC_ADDR_HIGH, 8'h80);
      repeat (40) @(posedge mclk);
      rdc(`ITC_ADDR_HIGH, 8'h00);
      `CHK(interval_irq_r, 1'b0)
   endtask : t_supply_off

   task automatic finish_test;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test

   initial begin
      reset = 1'b1;
      cpu_addr = 20'h00000;
      cpu_wdata = 8'h00;
      cpu_we = 1'b0;
      cpu_re = 1'b0;
      timer_clock_gate = 1'b0;
      osc_cnt = 3'h0;
      num_errors = 0;
      check_count = 0;
      cycles = 0;
      repeat (4) @(posedge mclk);
      #1 reset = 1'b0;
      t_reset_gate();
      t_run_short();
      t_run_wide();
      t_supply_off();
      finish_test();
   end
endmodule : tb_top
